// ==== logic/udtc_consts.svh ====
// Constants for the up/down threshold counter: offsets, fields, resets and timing.
// Operation
// - A high clear input forces the tally and the switching output to zero.
// - Only rising edges of the counting input are counted; falling edges are ignored.
// - Direction input low counts up, direction input high counts down.
// - Each counted rising edge moves the tally by exactly one, except down at 0 or up at 999999, where it holds.
// - Thresholds accept 0 to 999999; tally retention can be switched on or off.
// - While clear is high: output low, tally zero, incoming pulses discarded.
// - Without retention power loss clears tally and output; with it the tally survives.
// - Set above clear: output rises at tally >= set, falls below clear.
// - Set below clear: output high only strictly between set and clear.
// - Either threshold may follow the live value of another block by number.
// - An out-of-range referenced value is clamped to the nearest valid threshold.
// - Thresholds are compared once per program scan, so fast pulses may overshoot.
`ifndef UDTC_CONSTS_SVH
`define UDTC_CONSTS_SVH

// Register addresses on the plain register port.
`define UDTC_ADDR_CTRL 4'h0
`define UDTC_ADDR_SET_THR 4'h1
`define UDTC_ADDR_CLR_THR 4'h2
`define UDTC_ADDR_TALLY 4'h3
`define UDTC_ADDR_STATUS 4'h4
`define UDTC_ADDR_EFF_SET 4'h5
`define UDTC_ADDR_EFF_CLR 4'h6

// Value range and reset values.
`define UDTC_TALLY_W 20
`define UDTC_TALLY_MAX 20'hF423F
`define UDTC_TALLY_RST 20'h00000
`define UDTC_SET_RST 20'h00000
`define UDTC_CLR_RST 20'h00000
`define UDTC_CTRL_RST 9'h000

// Block selection and retention marker.
`define UDTC_NUM_BLOCKS 8
`define UDTC_BLK_W 3
`define UDTC_RETAIN_MARK 16'hA5C3

// Program scan period.
`define UDTC_CLK_MHZ 20
`define UDTC_SCAN_TIME_US 1000
`define UDTC_SCAN_CYCLES (`UDTC_SCAN_TIME_US * `UDTC_CLK_MHZ)

`endif

// ==== logic/udtc_pkg.sv ====
// Types shared by the up/down threshold counter.
`default_nettype none
package udtc_pkg;

    // Source of one threshold: own register or another block's actual value.
    typedef struct packed {
        logic [2:0] blk;
        logic ext;
    } udtc_src_s;

    // Control register layout, bit 0 upward: retain, set source, clear source.
    typedef struct packed {
        udtc_src_s clr_src;
        udtc_src_s set_src;
        logic retain;
    } udtc_ctrl_s;

    // Start-up sequence after power-on reset.
    typedef enum logic [0:0] {
        UDTC_ST_RESTORE = 1'b0,
        UDTC_ST_RUN = 1'b1
    } udtc_state_e;

endpackage
`default_nettype wire

// ==== logic/udtc_counter.sv ====
// Up/down event counter with a two-threshold switching output.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "udtc_consts.svh"

module udtc_counter
#(
    parameter int NUM_BLOCKS = `UDTC_NUM_BLOCKS,
    parameter int SCAN_CYCLES = `UDTC_SCAN_CYCLES
)
(
    // Clock, reset and clock enable.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    // Function inputs arriving from pins.
    input wire logic count_in,
    input wire logic count_sense,
    input wire logic wipe_in,
    // Live signed actual values of other blocks, block 0 in the low word.
    input wire logic [NUM_BLOCKS*32-1:0] ref_values,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Results.
    output logic switch_out,
    output logic [19:0] pulse_tally,
    output logic scan_tick
);

    // Any signed value is pulled into the valid threshold range.
    function automatic logic [19:0] clamp_thr(input logic [31:0] raw);
        logic signed [31:0] sv;
        sv = signed'(raw);
        if (sv < 32'sh00000000)
        begin
            clamp_thr = 20'h00000;
        end
        else if (sv > 32'sh000F423F)
        begin
            clamp_thr = `UDTC_TALLY_MAX;
        end
        else
        begin
            clamp_thr = raw[19:0];
        end
    endfunction

    // Picks the actual value of a numbered block; missing blocks read as zero.
    function automatic logic [31:0] pick_ref(input logic [2:0] blk,
                                             input logic [NUM_BLOCKS*32-1:0] vals);
        int idx;
        idx = int'(blk);
        if (idx < NUM_BLOCKS)
        begin
            pick_ref = vals[idx*32 +: 32];
        end
        else
        begin
            pick_ref = 32'h00000000;
        end
    endfunction

    // Pin synchronisers, three stages each.
    logic [2:0] cnt_sync_reg;
    logic [2:0] dir_sync_reg;
    logic [2:0] wipe_sync_reg;
    logic cnt_lvl_reg;
    logic dir_lvl_reg;
    logic wipe_lvl_reg;

    // Core state.
    logic [19:0] tally_reg;
    logic [19:0] tally_next;
    logic switch_reg;
    logic switch_next;
    logic [31:0] scan_cnt_reg;
    logic scan_tick_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_next;
    logic restored_reg;
    udtc_pkg::udtc_state_e state_reg;
    udtc_pkg::udtc_ctrl_s ctrl_reg;
    logic [19:0] set_thr_reg;
    logic [19:0] clr_thr_reg;

    // Retained copy, kept in storage that no reset touches.
    // Power-up content reads as an empty copy, so the first start never restores garbage.
    logic [19:0] keep_tally_reg = 20'h00000;
    logic [15:0] keep_mark_reg = 16'h0000;

    // Filtered levels, edges and derived values.
    wire logic cnt_new = cnt_sync_reg[2];
    wire logic cnt_agree = (cnt_sync_reg[1] == cnt_sync_reg[2]);
    wire logic dir_agree = (dir_sync_reg[1] == dir_sync_reg[2]);
    wire logic wipe_agree = (wipe_sync_reg[1] == wipe_sync_reg[2]);
    wire logic cnt_rise = cnt_agree && cnt_new && !cnt_lvl_reg;
    wire logic scan_last = (scan_cnt_reg >= 32'(SCAN_CYCLES - 1));
    wire logic running = (state_reg == udtc_pkg::UDTC_ST_RUN);
    wire logic keep_valid = (keep_mark_reg == `UDTC_RETAIN_MARK);
    wire logic at_max = (tally_reg == `UDTC_TALLY_MAX);
    wire logic at_min = (tally_reg == 20'h00000);

    // Both thresholds as the comparator sees them.
    wire logic [31:0] set_ref = pick_ref(ctrl_reg.set_src.blk, ref_values);
    wire logic [31:0] clr_ref = pick_ref(ctrl_reg.clr_src.blk, ref_values);
    wire logic [19:0] eff_set = ctrl_reg.set_src.ext ? clamp_thr(set_ref) : set_thr_reg;
    wire logic [19:0] eff_clr = ctrl_reg.clr_src.ext ? clamp_thr(clr_ref) : clr_thr_reg;
    wire logic hyst_mode = (eff_set >= eff_clr);

    // Comparator terms.
    wire logic reach_set = (tally_reg >= eff_set);
    wire logic below_clr = (tally_reg < eff_clr);
    wire logic in_window = (tally_reg > eff_set) && (tally_reg < eff_clr);

    // Register port decode.
    wire logic wr_ctrl = reg_wr && (reg_addr == `UDTC_ADDR_CTRL);
    wire logic wr_set = reg_wr && (reg_addr == `UDTC_ADDR_SET_THR);
    wire logic wr_clr = reg_wr && (reg_addr == `UDTC_ADDR_CLR_THR);

    // Outputs straight from flip-flops.
    assign pulse_tally = tally_reg;
    assign switch_out = switch_reg;
    assign scan_tick = scan_tick_reg;
    assign reg_rdata = rdata_reg;

    // Pins are asynchronous; only the last two stages feed the filtered levels.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_sync_reg <= 3'h0;
            dir_sync_reg <= 3'h0;
            wipe_sync_reg <= 3'h0;
        end
        else if (clk_en)
        begin
            cnt_sync_reg <= {cnt_sync_reg[1:0], count_in};
            dir_sync_reg <= {dir_sync_reg[1:0], count_sense};
            wipe_sync_reg <= {wipe_sync_reg[1:0], wipe_in};
        end
    end

    // A level change is accepted only once two stages agree, which rejects a lone glitch.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_lvl_reg <= 1'b0;
            dir_lvl_reg <= 1'b0;
            wipe_lvl_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cnt_agree)
            begin
                cnt_lvl_reg <= cnt_sync_reg[2];
            end
            if (dir_agree)
            begin
                dir_lvl_reg <= dir_sync_reg[2];
            end
            if (wipe_agree)
            begin
                wipe_lvl_reg <= wipe_sync_reg[2];
            end
        end
    end

    // Next tally: clear dominates, then a counted edge in the chosen direction.
    always_comb
    begin
        tally_next = tally_reg;
        if (wipe_lvl_reg)
        begin
            tally_next = `UDTC_TALLY_RST;
        end
        else if (!running)
        begin
            tally_next = keep_valid ? keep_tally_reg : `UDTC_TALLY_RST;
        end
        else if (cnt_rise && !dir_lvl_reg)
        begin
            tally_next = at_max ? tally_reg : tally_reg + 20'h00001;
        end
        else if (cnt_rise && dir_lvl_reg)
        begin
            tally_next = at_min ? tally_reg : tally_reg - 20'h00001;
        end
    end

    // Apart from clear, the output moves only on a scan tick, so a fast burst can step past a limit.
    always_comb
    begin
        switch_next = switch_reg;
        if (wipe_lvl_reg)
        begin
            switch_next = 1'b0;
        end
        else if (scan_tick_reg && hyst_mode)
        begin
            if (reach_set)
            begin
                switch_next = 1'b1;
            end
            else if (below_clr)
            begin
                switch_next = 1'b0;
            end
        end
        else if (scan_tick_reg)
        begin
            switch_next = in_window;
        end
    end

    // Tally, output and start-up sequence.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tally_reg <= `UDTC_TALLY_RST;
            switch_reg <= 1'b0;
            state_reg <= udtc_pkg::UDTC_ST_RESTORE;
            restored_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            tally_reg <= tally_next;
            switch_reg <= switch_next;
            state_reg <= udtc_pkg::UDTC_ST_RUN;
            if (!running)
            begin
                restored_reg <= keep_valid;
            end
        end
    end

    // Program scan timer; one tick per scan period.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            scan_cnt_reg <= 32'h00000000;
            scan_tick_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            scan_cnt_reg <= scan_last ? 32'h00000000 : scan_cnt_reg + 32'h00000001;
            scan_tick_reg <= scan_last;
        end
    end

    // Retained storage has no reset on purpose: it must outlive a power-on reset.
    // It is frozen during the restore cycle so the cleared tally cannot overwrite it.
    always_ff @(posedge clk_sys)
    begin
        if (clk_en && running)
        begin
            keep_tally_reg <= tally_next;
            keep_mark_reg <= ctrl_reg.retain ? `UDTC_RETAIN_MARK : 16'h0000;
        end
    end

    // Software registers; written thresholds are clamped into range.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_reg <= `UDTC_CTRL_RST;
            set_thr_reg <= `UDTC_SET_RST;
            clr_thr_reg <= `UDTC_CLR_RST;
        end
        else if (clk_en)
        begin
            if (!running)
            begin
                ctrl_reg.retain <= keep_valid;
            end
            else if (wr_ctrl)
            begin
                ctrl_reg <= reg_wdata[8:0];
            end
            if (wr_set)
            begin
                set_thr_reg <= clamp_thr(reg_wdata);
            end
            if (wr_clr)
            begin
                clr_thr_reg <= clamp_thr(reg_wdata);
            end
        end
    end

    // Read selection; unmapped addresses read as zero.
    always_comb
    begin
        rd_next = 32'h00000000;
        if (reg_addr == `UDTC_ADDR_CTRL)
        begin
            rd_next = {23'h000000, ctrl_reg};
        end
        else if (reg_addr == `UDTC_ADDR_SET_THR)
        begin
            rd_next = {12'h000, set_thr_reg};
        end
        else if (reg_addr == `UDTC_ADDR_CLR_THR)
        begin
            rd_next = {12'h000, clr_thr_reg};
        end
        else if (reg_addr == `UDTC_ADDR_TALLY)
        begin
            rd_next = {12'h000, tally_reg};
        end
        else if (reg_addr == `UDTC_ADDR_STATUS)
        begin
            rd_next = {28'h0000000, hyst_mode, restored_reg, wipe_lvl_reg, switch_reg};
        end
        else if (reg_addr == `UDTC_ADDR_EFF_SET)
        begin
            rd_next = {12'h000, eff_set};
        end
        else if (reg_addr == `UDTC_ADDR_EFF_CLR)
        begin
            rd_next = {12'h000, eff_clr};
        end
    end

    // Read data stand for exactly one cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= 32'h00000000;
        end
        else if (clk_en)
        begin
            rdata_reg <= reg_rd ? rd_next : 32'h00000000;
        end
    end

endmodule // udtc_counter
`default_nettype wire

// ==== verification/udtc_counter_sva.sv ====
// Port-level checker for the up/down threshold counter, with its bind.
`timescale 1ns/1ps
`default_nettype none

module udtc_counter_sva
#(
    parameter int NUM_BLOCKS = 8,
    parameter int SCAN_CYCLES = 16
)
(
    // Clock, reset and pins.
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic count_in,
    input wire logic count_sense,
    input wire logic wipe_in,
    input wire logic [NUM_BLOCKS*32-1:0] ref_values,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Results.
    input wire logic switch_out,
    input wire logic [19:0] pulse_tally,
    input wire logic scan_tick
);
    logic [19:0] set_q, clr_q, wd_cl;
    logic ext_q, exp_sw;
    logic [3:0] quiet_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Own thresholds are mirrored with the same clamp; referenced sources are not followed.
    assign wd_cl = reg_wdata[31] ? 20'h00000 :
        (reg_wdata > 32'h000F423F ? 20'hF423F : reg_wdata[19:0]);
    assign exp_sw = (set_q >= clr_q) ?
        (pulse_tally >= set_q || (pulse_tally >= clr_q && switch_out)) :
        (pulse_tally > set_q && pulse_tally < clr_q);

    // Shadow copies, plus how long the clear pin has been quiet.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            set_q <= 20'h00000;
            clr_q <= 20'h00000;
            ext_q <= 1'b0;
            quiet_q <= 4'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == 4'h1)
                set_q <= wd_cl;
            if (reg_wr && reg_addr == 4'h2)
                clr_q <= wd_cl;
            if (reg_wr && reg_addr == 4'h0)
                ext_q <= reg_wdata[1] | reg_wdata[5];
            quiet_q <= wipe_in ? 4'h0 : quiet_q + 4'(quiet_q != 4'hF);
        end
    end

    wipe_zero_a: assert property (wipe_in [*8] |-> pulse_tally == 20'h00000 && !switch_out)
        else $error("tally or switch not zero while clear held");
    tally_step_a: assert property ($past(resetn, 2) && $changed(pulse_tally) |->
        pulse_tally == $past(pulse_tally) + 20'h00001 ||
        pulse_tally == $past(pulse_tally) - 20'h00001 || pulse_tally == 20'h00000)
        else $error("tally moved by more than one");
    tally_top_a: assert property (pulse_tally <= 20'hF423F)
        else $error("tally above top value");
    tick_gap_a: assert property (scan_tick |=> (!scan_tick) [*8])
        else $error("scan ticks too close");
    scan_period_a: assert property (scan_tick |-> ##SCAN_CYCLES scan_tick)
        else $error("scan period wrong");
    switch_hold_a: assert property ($changed(switch_out) |-> $past(scan_tick) || !switch_out)
        else $error("switch rose outside a scan");
    switch_rule_a: assert property (scan_tick && !ext_q && quiet_q == 4'hF |->
        ##1 switch_out == $past(exp_sw))
        else $error("switch level differs from thresholds");
    tally_read_a: assert property (reg_rd && reg_addr == 4'h3 |=>
        reg_rdata == {12'h000, $past(pulse_tally)})
        else $error("tally register read wrong");

    cover property (scan_tick && switch_out);
    cover property (wipe_in [*8]);
    cover property (reg_rd && reg_addr == 4'h5);
endmodule // udtc_counter_sva

bind udtc_counter udtc_counter_sva #(.NUM_BLOCKS(NUM_BLOCKS), .SCAN_CYCLES(SCAN_CYCLES)) chk (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .count_in(count_in),
    .count_sense(count_sense), .wipe_in(wipe_in), .ref_values(ref_values),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .switch_out(switch_out), .pulse_tally(pulse_tally),
    .scan_tick(scan_tick));
`default_nettype wire

// ==== verification/udtc_pulse_src.sv ====
// Behavioural pulse source that drives the counting pin.
`timescale 1ns/1ps
`default_nettype none

module udtc_pulse_src
(
    // Clock and request: one pulse, each phase as many cycles as the larger of width and four.
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic [3:0] width,
    // Counting pin and busy flag.
    output logic count_in,
    output logic busy
);
    logic [4:0] left_q = 5'h00;
    logic [4:0] half_q = 5'h04;

    // Phases of four cycles or more keep the pin slow next to the input filter.
    assign count_in = left_q > half_q;
    assign busy = left_q != 5'h00;
    always @(posedge clk_sys)
    begin
        if (fire && !busy)
        begin
            half_q <= {1'b0, width < 4'h4 ? 4'h4 : width};
            left_q <= {width < 4'h4 ? 4'h4 : width, 1'b0};
        end
        else if (busy)
            left_q <= left_q - 5'h01;
    end
endmodule // udtc_pulse_src
`default_nettype wire

// ==== verification/udtc_counter_bench.sv ====
// Self-checking bench for the up/down threshold counter.
`timescale 1ns/1ps
`default_nettype none

module udtc_counter_bench;
    logic clk_sys, resetn, clk_en, count_in, count_sense, wipe_in;
    logic [255:0] ref_values;
    logic [3:0] reg_addr, width;
    logic [31:0] reg_wdata, reg_rdata, d, seed;
    logic reg_wr, reg_rd, switch_out, scan_tick, fire, busy, ms;
    logic [19:0] pulse_tally, mt, st, ct;
    logic [31:0] rv [3];
    logic [31:0] ev [3];
    udtc_pkg::udtc_ctrl_s ctl;
    int err_count, samples_checked, cycles;

    udtc_counter #(.NUM_BLOCKS(8), .SCAN_CYCLES(16)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .count_in(count_in),
        .count_sense(count_sense), .wipe_in(wipe_in), .ref_values(ref_values),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .switch_out(switch_out), .pulse_tally(pulse_tally),
        .scan_tick(scan_tick));
    udtc_pulse_src src (.clk_sys(clk_sys), .fire(fire), .width(width), .count_in(count_in),
        .busy(busy));

    // Clock, and a bound on run length well above the expected few thousand cycles.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register port: one-cycle strobes, read data taken in the following cycle.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask

    // Next switch level from tally, thresholds and the present level.
    function automatic logic swf(input logic [19:0] t, s, c, input logic p);
        if (s >= c)
            return t >= s || (t >= c && p);
        return t > s && t < c;
    endfunction

    // One pulse in the given direction; the model tally saturates at zero.
    task automatic pulse(input logic dn);
        @(posedge clk_sys);
        count_sense <= dn;
        fire <= 1'b1;
        width <= 4'h4 | 4'($random(seed) & 3);
        @(posedge clk_sys);
        fire <= 1'b0;
        @(negedge clk_sys);
        for (int k = 0; k < 40 && busy !== 1'b0; k++)
            @(negedge clk_sys);
        mt = dn ? (mt == 20'h00000 ? mt : mt - 20'h00001) : mt + 20'h00001;
    endtask

    // Let two scans pass, then compare tally and switch with the model.
    task automatic settle();
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(pulse_tally), 32'(mt));
        ms = swf(mt, st, ct, ms);
        chk(32'(switch_out), 32'(ms));
        rd(4'h3, d);
        chk(d, 32'(mt));
    endtask

    task automatic power_cycle();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        {st, ct, ms} = 41'h0;
    endtask

    // Main sequence: reset, random walk, clear, referenced thresholds, retention.
    initial
    begin
        seed = 32'h6A17D386;
        {err_count, samples_checked, cycles} = 96'h0;
        {resetn, count_sense, wipe_in, reg_wr, reg_rd, fire, ms} = 7'h00;
        clk_en = 1'b1;
        ref_values = {8{32'($random(seed))}};
        {reg_addr, width, reg_wdata, mt, st, ct} = 100'h0;
        rv = '{32'hFFFFFFF9, 32'h001E8480, 32'h00000009};
        ev = '{32'h00000000, 32'h000F423F, 32'h00000009};
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            rd(i == 7 ? 4'hA : 4'(i), d);
            chk(d, i == 4 ? 32'h00000008 : 32'h00000000);
        end
        for (int i = 0; i < 40; i++)
        begin
            if (i % 4 == 0)
            begin
                // Catch up with scans since the last check, then write both limits
                // right after a tick so that no scan sees one old and one new limit.
                ms = swf(mt, st, ct, ms);
                while (scan_tick !== 1'b1)
                    @(negedge clk_sys);
                st = 20'($unsigned($random(seed)) % 13);
                ct = 20'($unsigned($random(seed)) % 13);
                wr(4'h1, 32'(st));
                wr(4'h2, 32'(ct));
                settle();
            end
            pulse(1'($random(seed)));
            settle();
        end
        repeat (3) pulse(1'b0);
        @(posedge clk_sys);
        wipe_in <= 1'b1;
        pulse(1'b0);
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        {mt, ms} = 21'h0;
        chk(32'(pulse_tally), 32'h0);
        rd(4'h4, d);
        chk(32'(d[1:0]), 32'h2);
        ctl = '0;
        ctl.set_src.ext = 1'b1;
        ctl.set_src.blk = 3'h2;
        ctl.clr_src.ext = 1'b1;
        ctl.clr_src.blk = 3'h2;
        wr(4'h0, 32'(ctl));
        for (int i = 0; i < 3; i++)
        begin
            ref_values[95:64] <= rv[i];
            rd(4'h5, d);
            chk(d, ev[i]);
            rd(4'h6, d);
            chk(d, ev[i]);
        end
        wr(4'h0, 32'h00000001);
        wipe_in <= 1'b0;
        repeat (3) pulse(1'b0);
        settle();
        power_cycle();
        chk(32'(pulse_tally), 32'(mt));
        rd(4'h4, d);
        chk(d, 32'h0000000C);
        wr(4'h0, 32'h00000000);
        power_cycle();
        mt = 20'h00000;
        chk(32'(pulse_tally), 32'h0);
        settle();
        end_of_test();
    end
endmodule // udtc_counter_bench
`default_nettype wire
